// ===== core/ssp_core.sv
/*
  Serial port with synchronous slave, synchronous master and asynchronous
  transmit/receive, two-word receive buffer, sleep operation and auto-baud.
  Assumes REF_CLK much faster than the link clock, SLEEP driven from the
  same clock, and the pin wires resolved outside from the enables.
*/
// Contract
// (RL1) clock source bit picks external or internal clock
// (RL2) slave receive uses continuous enable only
// (RL3) receive enables override transmit in sync
// (RL4) only sync slave keeps shifting asleep
// (RL5) asleep, received word sets receive flag
// (RL6) wake resumes; global enable also vectors
// (RL7) asleep, holding moves to shifter, sets flag
// (RL8) holding write clears transmit flag
// (RL9) master supplies clock and receive data
// (RL10) holding write starts slave transmission
// (RL11) nine-bit select adds ninth transmit bit
// (RL12) nine-bit receive presents ninth bit
// (RL13) port enable low holds port reset
// (RL14) overrun clears via continuous enable or port
// (RL15) shift empty status, resets to one
// (RL16) polarity sets clock or line idle
// (RL17) wide select gives 16-bit baud counter
// (RL18) break: start, twelve zeros, stop, self-clears
// (RL19) address detect filters nine-bit characters
// (RL20) wake on edge, self-clears on rise
// (RL21) auto-baud measures sync field, flags overflow
// (RL22) receive idle status, resets to one
// (RL23) data changes leading, valid trailing edge
// (RL24) two-word buffer, third sets overrun
// (RL25) unimplemented bits read zero
`include "ssp_regs.svh"
`default_nettype none
module ssp_core (
  input wire logic REF_CLK,
  input wire logic RSTN,
  input wire logic [2:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  input wire logic SLEEP,
  input wire logic CK_IN,
  output logic CK_OUT,
  output logic CK_OE,
  input wire logic DT_IN,
  output logic DT_OUT,
  output logic DT_OE,
  output logic WAKE,
  output logic IRQ
);
  import ssp_pkg::*;

  function automatic logic [3:0] f_nbits(input logic nine);
    f_nbits = nine ? `SSP_BITS9 : `SSP_BITS8;
  endfunction

  // lsb-first shifting into bit 8 leaves an 8-bit word in [8:1]
  function automatic logic [8:0] f_word(input logic [8:0] sr, input logic nine);
    f_word = nine ? sr : {1'b0, sr[8:1]};
  endfunction

  logic [7:0] tsc_q, rsc_q, bcon_q, int_q, rdata_q;
  logic [15:0] brg_q, bcnt_q;
  logic [1:0] pre_q;
  logic ck_s1_q, ck_s2_q, dt_s1_q, dt_s2_q, lvl_prev_q, dt_prev_q;
  logic mck_q, ck_out_q, ck_oe_q, dt_out_q, dt_oe_q, wake_q, irq_q;
  ssp_tx_state_t tst_q;
  logic [8:0] tsr_q, thr_q, rsr_q, f0_q, f1_q, pword_q;
  logic [3:0] tcnt_q, atick_q, rcnt_q, osc_q;
  logic thr_full_q, empty_q, dt_q, atx_q, brk_q;
  logic arx_act_q, push_q, pferr_q, framing_error_flag_q, overrun_flag_q, wedge_q;
  logic [1:0] fcnt_q;
  logic ab_act_q;
  logic [2:0] ab_n_q;
  logic [22:0] ab_cnt_q;

  // =====================================================================
  // decoded controls
  logic clksrc, sync, transmit_enable, pen, crx, srx, clock_polarity, wide, master, slave, en;
  logic tick, lvl, lead, trail, fall_dt, rise_dt, tx_mode, rx_mode;
  logic bit_tick, brk_done, ab_done, rxif, txif;
  logic wr_tsc, wr_rsc, wr_bcon, wr_thr, wr_int, rd_rdr;
  logic [1:0] pre_top;
  assign clksrc = tsc_q[`SSP_TSC_CLKSRC];
  assign sync = tsc_q[`SSP_TSC_SYNC];
  assign transmit_enable = tsc_q[`SSP_TSC_TRANSMIT_ENABLE];
  assign pen = rsc_q[`SSP_RSC_PEN];
  assign crx = rsc_q[`SSP_RSC_CRX];
  assign srx = rsc_q[`SSP_RSC_SRX];
  assign clock_polarity = bcon_q[`SSP_BCON_POL];
  assign wide = bcon_q[`SSP_BCON_WIDE];
  assign master = sync & clksrc;
  assign slave = sync & ~clksrc;
  assign en = ~SLEEP | slave; // RL4
  assign wr_tsc = WR & (ADDR == `SSP_OFS_TSC);
  assign wr_rsc = WR & (ADDR == `SSP_OFS_RSC);
  assign wr_bcon = WR & (ADDR == `SSP_OFS_BCON);
  assign wr_thr = WR & (ADDR == `SSP_OFS_THR);
  assign wr_int = WR & (ADDR == `SSP_OFS_INT);
  assign rd_rdr = RD & (ADDR == `SSP_OFS_RDR);
  assign tx_mode = pen & sync & transmit_enable & ~(srx | crx); // RL3
  assign rx_mode = pen & sync & (slave ? crx : (crx | srx)); // RL2
  assign lvl = master ? mck_q : ck_s2_q; // RL1
  assign lead = (lvl != lvl_prev_q) & (lvl_prev_q == clock_polarity); // RL16
  assign trail = (lvl != lvl_prev_q) & (lvl == clock_polarity);
  assign fall_dt = dt_prev_q & ~dt_s2_q;
  assign rise_dt = ~dt_prev_q & dt_s2_q;
  assign bit_tick = tick & (atick_q == `SSP_OVS_LAST);
  assign brk_done = (tst_q == TX_STOP) & bit_tick & brk_q;
  assign ab_done = ab_act_q & fall_dt & ((ab_n_q + 3'h1) == `SSP_AB_EDGES);
  assign rxif = (fcnt_q != 2'h0) | wedge_q;
  assign txif = ~thr_full_q; // RL8
  assign pre_top = sync ? 2'h1 : (tsc_q[`SSP_TSC_HBAUD] ? 2'h0 : 2'h3);
  assign tick = ~SLEEP & pen & (bcnt_q == 16'h0000) & (pre_q == pre_top);

  // =====================================================================
  // registers
  always_ff @(posedge REF_CLK or negedge RSTN)
    if (!RSTN)
      tsc_q <= `SSP_TSC_RST;
    else if (wr_tsc)
      tsc_q <= WDATA & `SSP_TSC_WMASK; // RL25
    else if (brk_done)
      tsc_q[`SSP_TSC_BREAK] <= 1'b0; // RL18

  always_ff @(posedge REF_CLK or negedge RSTN)
    if (!RSTN)
      rsc_q <= `SSP_RSC_RST;
    else if (wr_rsc)
      rsc_q <= WDATA & `SSP_RSC_WMASK;
    else if (master & srx & push_q)
      rsc_q[`SSP_RSC_SRX] <= 1'b0;

  always_ff @(posedge REF_CLK or negedge RSTN)
    if (!RSTN)
      bcon_q <= `SSP_BCON_RST;
    else
    begin
      if (wr_bcon)
        bcon_q <= WDATA & `SSP_BCON_WMASK;
      if (wedge_q & rise_dt & ~sync)
        bcon_q[`SSP_BCON_WAKE] <= 1'b0; // RL20
      if (ab_done)
        bcon_q[`SSP_BCON_AUTO] <= 1'b0; // RL21
      if (ab_act_q & (&ab_cnt_q))
        bcon_q[`SSP_BCON_ABOVF] <= 1'b1; // RL21
    end

  always_ff @(posedge REF_CLK or negedge RSTN)
    if (!RSTN)
      int_q <= `SSP_INT_RST;
    else if (wr_int)
      int_q <= WDATA & `SSP_INT_WMASK;

  always_ff @(posedge REF_CLK or negedge RSTN)
    if (!RSTN)
      brg_q <= 16'h0000;
    else if (ab_done)
      brg_q <= ab_cnt_q[22:7];
    else if (WR & (ADDR == `SSP_OFS_BAUDLO))
      brg_q[7:0] <= WDATA;
    else if (WR & (ADDR == `SSP_OFS_BAUDHI))
      brg_q[15:8] <= WDATA;

  always_ff @(posedge REF_CLK or negedge RSTN)
    if (!RSTN)
      rdata_q <= 8'h00;
    else if (RD)
      case (ADDR)
        `SSP_OFS_TSC: rdata_q <= {tsc_q[7:2], empty_q, tsc_q[0]}; // RL15
        `SSP_OFS_RSC: rdata_q <= {rsc_q[7:3], framing_error_flag_q, overrun_flag_q, f0_q[8]}; // RL12
        `SSP_OFS_BCON: rdata_q <= {bcon_q[7], ~arx_act_q, bcon_q[5:0]}; // RL22
        `SSP_OFS_RDR: rdata_q <= f0_q[7:0];
        `SSP_OFS_BAUDLO: rdata_q <= brg_q[7:0];
        `SSP_OFS_BAUDHI: rdata_q <= brg_q[15:8];
        `SSP_OFS_INT: rdata_q <= {int_q[7:4], 2'b00, rxif, txif};
        default: rdata_q <= 8'h00;
      endcase

  // =====================================================================
  // baud generator; a baud register write restarts the count
  always_ff @(posedge REF_CLK or negedge RSTN)
    if (!RSTN)
    begin
      bcnt_q <= 16'h0000;
      pre_q <= 2'h0;
    end
    else if (!pen | (WR & ((ADDR == `SSP_OFS_BAUDLO) | (ADDR == `SSP_OFS_BAUDHI))))
    begin
      bcnt_q <= 16'h0000;
      pre_q <= 2'h0;
    end
    else if (!SLEEP)
    begin
      if (bcnt_q != 16'h0000)
        bcnt_q <= bcnt_q - 16'h0001;
      else
      begin
        bcnt_q <= wide ? brg_q : {8'h00, brg_q[7:0]}; // RL17
        pre_q <= (pre_q == pre_top) ? 2'h0 : pre_q + 2'h1;
      end
    end

  // =====================================================================
  // pin synchronisers and master clock
  always_ff @(posedge REF_CLK or negedge RSTN)
    if (!RSTN)
    begin
      ck_s1_q <= 1'b0;
      ck_s2_q <= 1'b0;
      dt_s1_q <= 1'b1;
      dt_s2_q <= 1'b1;
      lvl_prev_q <= 1'b0;
      dt_prev_q <= 1'b1;
    end
    else
    begin
      ck_s1_q <= CK_IN;
      ck_s2_q <= ck_s1_q;
      dt_s1_q <= DT_IN;
      dt_s2_q <= dt_s1_q;
      lvl_prev_q <= lvl;
      dt_prev_q <= dt_s2_q;
    end

  // clock pauses at its idle level when there is nothing to move
  always_ff @(posedge REF_CLK or negedge RSTN)
    if (!RSTN)
      mck_q <= 1'b0;
    else if (!master | !((tst_q == TX_DATA) | rx_mode))
      mck_q <= clock_polarity;
    else if (tick)
      mck_q <= ~mck_q; // RL1
  // =====================================================================
  // transmitter
  always_ff @(posedge REF_CLK or negedge RSTN)
    if (!RSTN)
    begin
      tst_q <= TX_IDLE;
      tsr_q <= 9'h000;
      thr_q <= 9'h000;
      tcnt_q <= 4'h0;
      atick_q <= 4'h0;
      thr_full_q <= 1'b0;
      empty_q <= 1'b1;
      dt_q <= 1'b0;
      atx_q <= 1'b1;
      brk_q <= 1'b0;
    end
    else if (!pen)
    begin
      tst_q <= TX_IDLE; // RL13
      thr_full_q <= 1'b0;
      empty_q <= 1'b1;
      atx_q <= 1'b1;
      brk_q <= 1'b0;
    end
    else if (en)
    begin
      if ((tst_q == TX_IDLE) & thr_full_q & (sync ? tx_mode : transmit_enable))
      begin
        thr_full_q <= 1'b0; // RL7
        empty_q <= 1'b0;
        atick_q <= 4'h0;
        brk_q <= ~sync & tsc_q[`SSP_TSC_BREAK]; // RL18
        tsr_q <= (~sync & tsc_q[`SSP_TSC_BREAK]) ? 9'h000 : thr_q;
        if (sync)
        begin
          tst_q <= TX_DATA; // RL10
          tcnt_q <= f_nbits(tsc_q[`SSP_TSC_NINE]); // RL11
        end
        else
        begin
          tst_q <= TX_START;
          atx_q <= 1'b0;
          tcnt_q <= tsc_q[`SSP_TSC_BREAK] ? `SSP_BREAK_BITS : f_nbits(tsc_q[`SSP_TSC_NINE]);
        end
      end
      else if (sync & (tst_q == TX_DATA))
      begin
        if (lead & (tcnt_q != 4'h0))
        begin
          dt_q <= tsr_q[0]; // RL23
          tsr_q <= {1'b0, tsr_q[8:1]};
          tcnt_q <= tcnt_q - 4'h1;
        end
        else if (trail & (tcnt_q == 4'h0))
        begin
          tst_q <= TX_IDLE;
          empty_q <= 1'b1; // RL15
        end
      end
      else if (!sync & (tst_q != TX_IDLE) & tick)
      begin
        atick_q <= atick_q + 4'h1;
        if (bit_tick)
          case (tst_q)
            TX_START, TX_DATA:
              if (tcnt_q != 4'h0)
              begin
                tst_q <= TX_DATA;
                atx_q <= tsr_q[0];
                tsr_q <= {1'b0, tsr_q[8:1]};
                tcnt_q <= tcnt_q - 4'h1;
              end
              else
              begin
                tst_q <= TX_STOP;
                atx_q <= 1'b1;
              end
            TX_STOP:
            begin
              tst_q <= TX_IDLE;
              empty_q <= 1'b1;
              brk_q <= 1'b0;
            end
            default: tst_q <= TX_IDLE;
          endcase
      end
      if (wr_thr)
      begin
        thr_q <= {tsc_q[`SSP_TSC_TX9BIT], WDATA}; // RL10
        thr_full_q <= 1'b1; // RL8
      end
    end

  // =====================================================================
  // receiver: sync samples on the trailing edge, async mid-bit
  always_ff @(posedge REF_CLK or negedge RSTN)
    if (!RSTN)
    begin
      rsr_q <= 9'h000;
      rcnt_q <= 4'h0;
      osc_q <= 4'h0;
      arx_act_q <= 1'b0;
      push_q <= 1'b0;
      pword_q <= 9'h000;
      pferr_q <= 1'b0;
    end
    else
    begin
      push_q <= 1'b0;
      if (!pen | !en)
      begin
        rcnt_q <= pen ? rcnt_q : 4'h0; // RL13
        arx_act_q <= pen & arx_act_q;
      end
      else if (sync)
      begin
        arx_act_q <= 1'b0;
        if (!rx_mode)
          rcnt_q <= 4'h0; // partial word dropped
        else if (trail & ~overrun_flag_q) // RL24
        begin
          rsr_q <= {dt_s2_q, rsr_q[8:1]}; // RL9
          if (rcnt_q == f_nbits(rsc_q[`SSP_RSC_NINE]) - 4'h1)
          begin
            rcnt_q <= 4'h0;
            push_q <= 1'b1; // RL5
            pferr_q <= 1'b0;
            pword_q <= f_word({dt_s2_q, rsr_q[8:1]}, rsc_q[`SSP_RSC_NINE]); // RL12
          end
          else
            rcnt_q <= rcnt_q + 4'h1;
        end
      end
      else if (!arx_act_q)
      begin
        if (fall_dt & crx & ~bcon_q[`SSP_BCON_AUTO] & ~overrun_flag_q)
        begin
          arx_act_q <= 1'b1;
          osc_q <= 4'h0;
          rcnt_q <= 4'h0;
        end
      end
      else if (tick)
      begin
        osc_q <= osc_q + 4'h1;
        if (osc_q == `SSP_OVS_MID)
        begin
          rcnt_q <= rcnt_q + 4'h1;
          if ((rcnt_q == 4'h0) & dt_s2_q)
            arx_act_q <= 1'b0;
          else if (rcnt_q == f_nbits(rsc_q[`SSP_RSC_NINE]) + 4'h1)
          begin
            arx_act_q <= 1'b0;
            pferr_q <= ~dt_s2_q;
            pword_q <= f_word(rsr_q, rsc_q[`SSP_RSC_NINE]);
            push_q <= ~(rsc_q[`SSP_RSC_NINE] & rsc_q[`SSP_RSC_ADET]) |
                      rsr_q[8]; // RL19
          end
          else if (rcnt_q != 4'h0)
            rsr_q <= {dt_s2_q, rsr_q[8:1]};
        end
      end
    end

  // =====================================================================
  // two-word receive buffer
  always_ff @(posedge REF_CLK or negedge RSTN)
    if (!RSTN)
    begin
      f0_q <= 9'h000;
      f1_q <= 9'h000;
      fcnt_q <= 2'h0;
      framing_error_flag_q <= 1'b0;
    end
    else if (!pen)
      fcnt_q <= 2'h0;
    else if (rd_rdr & (fcnt_q != 2'h0))
    begin
      f0_q <= (push_q & ~overrun_flag_q & (fcnt_q == 2'h1)) ? pword_q : f1_q;
      if (!(push_q & ~overrun_flag_q))
        fcnt_q <= fcnt_q - 2'h1;
      else if (fcnt_q == 2'h2)
        f1_q <= pword_q;
      if (push_q & ~overrun_flag_q)
        framing_error_flag_q <= pferr_q;
    end
    else if (push_q & ~overrun_flag_q & (fcnt_q != 2'h2)) // RL24
    begin
      if (fcnt_q == 2'h0)
        f0_q <= pword_q;
      else
        f1_q <= pword_q;
      fcnt_q <= fcnt_q + 2'h1;
      framing_error_flag_q <= pferr_q;
    end

  // set wins over every clear
  always_ff @(posedge REF_CLK or negedge RSTN)
    if (!RSTN)
      overrun_flag_q <= 1'b0;
    else if (push_q & (fcnt_q == 2'h2) & ~rd_rdr)
      overrun_flag_q <= 1'b1; // RL24
    else if (!pen | !crx | (rd_rdr & srx))
      overrun_flag_q <= 1'b0; // RL14

  always_ff @(posedge REF_CLK or negedge RSTN)
    if (!RSTN)
      wedge_q <= 1'b0;
    else if (pen & ~sync & bcon_q[`SSP_BCON_WAKE] & fall_dt)
      wedge_q <= 1'b1; // RL20
    else if (rd_rdr | !pen)
      wedge_q <= 1'b0;

  // =====================================================================
  // auto-baud: first to fifth falling edge of the sync field is 8 bits
  always_ff @(posedge REF_CLK or negedge RSTN)
    if (!RSTN)
    begin
      ab_act_q <= 1'b0;
      ab_n_q <= 3'h0;
      ab_cnt_q <= 23'h000000;
    end
    else if (!pen | sync | ~bcon_q[`SSP_BCON_AUTO] | ab_done | (&ab_cnt_q))
      ab_act_q <= 1'b0;
    else if (!ab_act_q)
    begin
      if (fall_dt)
      begin
        ab_act_q <= 1'b1; // RL21
        ab_n_q <= 3'h0;
        ab_cnt_q <= 23'h000000;
      end
    end
    else
    begin
      ab_cnt_q <= ab_cnt_q + 23'h000001;
      if (fall_dt)
        ab_n_q <= ab_n_q + 3'h1;
    end

  // =====================================================================
  // pins and wake-up outputs
  always_ff @(posedge REF_CLK or negedge RSTN)
    if (!RSTN)
    begin
      ck_out_q <= 1'b0;
      ck_oe_q <= 1'b0;
      dt_out_q <= 1'b0;
      dt_oe_q <= 1'b0;
      wake_q <= 1'b0;
      irq_q <= 1'b0;
    end
    else
    begin
      ck_out_q <= sync ? mck_q : (atx_q ^ clock_polarity); // RL16
      ck_oe_q <= pen & (sync ? clksrc : transmit_enable); // RL13
      dt_out_q <= dt_q;
      dt_oe_q <= tx_mode;
      wake_q <= int_q[`SSP_INT_PIE] &
                ((rxif & int_q[`SSP_INT_RXIE]) | (txif & int_q[`SSP_INT_TXIE])); // RL6
      irq_q <= int_q[`SSP_INT_GLOBAL] & int_q[`SSP_INT_PIE] &
               ((rxif & int_q[`SSP_INT_RXIE]) | (txif & int_q[`SSP_INT_TXIE])); // RL6
    end

  assign RDATA = rdata_q;
  assign CK_OUT = ck_out_q;
  assign CK_OE = ck_oe_q;
  assign DT_OUT = dt_out_q;
  assign DT_OE = dt_oe_q;
  assign WAKE = wake_q;
  assign IRQ = irq_q;
endmodule
`default_nettype wire

// ===== common/ssp_regs.svh
/*
  Register offsets, field positions, reset values and bit counts of the
  synchronous slave serial port. Assumes an 8-bit register port with a
  3-bit word address.
*/
`ifndef SSP_REGS_SVH
`define SSP_REGS_SVH
// =====================================================================
// offsets
`define SSP_OFS_TSC 3'h0
`define SSP_OFS_RSC 3'h1
`define SSP_OFS_BCON 3'h2
`define SSP_OFS_THR 3'h3
`define SSP_OFS_RDR 3'h4
`define SSP_OFS_BAUDLO 3'h5
`define SSP_OFS_BAUDHI 3'h6
`define SSP_OFS_INT 3'h7
// =====================================================================
// transmit_status_control fields
`define SSP_TSC_CLKSRC 7
`define SSP_TSC_NINE 6
`define SSP_TSC_TRANSMIT_ENABLE 5
`define SSP_TSC_SYNC 4
`define SSP_TSC_BREAK 3
`define SSP_TSC_HBAUD 2
`define SSP_TSC_EMPTY 1
`define SSP_TSC_TX9BIT 0
// receive_status_control fields
`define SSP_RSC_PEN 7
`define SSP_RSC_NINE 6
`define SSP_RSC_SRX 5
`define SSP_RSC_CRX 4
`define SSP_RSC_ADET 3
`define SSP_RSC_FRAME 2
`define SSP_RSC_OVR 1
`define SSP_RSC_RX9BIT 0
// baud_control fields
`define SSP_BCON_ABOVF 7
`define SSP_BCON_IDLE 6
`define SSP_BCON_POL 4
`define SSP_BCON_WIDE 3
`define SSP_BCON_WAKE 1
`define SSP_BCON_AUTO 0
// interrupt control fields
`define SSP_INT_GLOBAL 7
`define SSP_INT_PIE 6
`define SSP_INT_RXIE 5
`define SSP_INT_TXIE 4
`define SSP_INT_RXIF 1
`define SSP_INT_TXIF 0
// =====================================================================
// writable masks and reset values
`define SSP_TSC_WMASK 8'hFD
`define SSP_RSC_WMASK 8'hF8
`define SSP_BCON_WMASK 8'h9B
`define SSP_INT_WMASK 8'hF0
`define SSP_TSC_RST 8'h02
`define SSP_RSC_RST 8'h00
`define SSP_BCON_RST 8'h40
`define SSP_INT_RST 8'h00
// =====================================================================
// bit counts
`define SSP_OVS_LAST 4'hF
`define SSP_OVS_MID 4'h7
`define SSP_BREAK_BITS 4'hC
`define SSP_BITS8 4'h8
`define SSP_BITS9 4'h9
`define SSP_AB_EDGES 3'h4
`endif

// ===== common/ssp_pkg.sv
/*
  Types of the synchronous slave serial port.
  Assumes nothing of its surroundings.
*/
`default_nettype none
package ssp_pkg;
  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_START = 2'b01,
    TX_DATA = 2'b11,
    TX_STOP = 2'b10
  } ssp_tx_state_t;
endpackage
`default_nettype wire

// ===== test/ssp_properties.sv
/*
  Port checker of ssp_core: bus, pin-enable and wake/interrupt relations.
  Assumes the offsets of ssp_regs.svh and a single clock domain.
*/
`include "ssp_regs.svh"
`default_nettype none
module ssp_checker (
  input wire logic REF_CLK,
  input wire logic RSTN,
  input wire logic [2:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [7:0] RDATA,
  input wire logic SLEEP,
  input wire logic CK_IN,
  input wire logic CK_OUT,
  input wire logic CK_OE,
  input wire logic DT_IN,
  input wire logic DT_OUT,
  input wire logic DT_OE,
  input wire logic WAKE,
  input wire logic IRQ
);
  logic [7:0] tsc_q;
  logic [7:0] rsc_q;
  logic [7:0] int_q;
  logic pen;
  logic slave;
  logic rx_sync;
  // =========================================
  // shadows of written control bits; rx_sync relies on SRX, which self-clears in master receive
  always_ff @(posedge REF_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      tsc_q <= 8'h00;
      rsc_q <= 8'h00;
      int_q <= 8'h00;
    end
    else if (WR)
    begin
      if (ADDR == `SSP_OFS_TSC) tsc_q <= WDATA;
      if (ADDR == `SSP_OFS_RSC) rsc_q <= WDATA;
      if (ADDR == `SSP_OFS_INT) int_q <= WDATA;
    end
  end
  assign pen = rsc_q[`SSP_RSC_PEN];
  assign slave = pen && tsc_q[`SSP_TSC_SYNC] && !tsc_q[`SSP_TSC_CLKSRC];
  assign rx_sync = pen && tsc_q[`SSP_TSC_SYNC] && (rsc_q[`SSP_RSC_SRX] || rsc_q[`SSP_RSC_CRX]);
  // =========================================
  // properties; two-cycle antecedents allow for the registered pin enables
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RSTN);
  property p_irq_wake; IRQ |-> WAKE; endproperty
  a_irq_wake: assert property (p_irq_wake) else $error("irq without wake");
  property p_no_irq; !int_q[`SSP_INT_GLOBAL] [*2] |-> !IRQ; endproperty
  a_no_irq: assert property (p_no_irq) else $error("irq with global off");
  property p_no_wake; !int_q[`SSP_INT_PIE] && !$past(int_q[`SSP_INT_PIE]) |-> !WAKE; endproperty
  a_no_wake: assert property (p_no_wake) else $error("wake with peripheral off");
  property p_rst_quiet; $rose(RSTN) |-> !CK_OE && !DT_OE && !WAKE && !IRQ; endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("pins active after reset");
  property p_off_quiet; !pen [*2] |-> !CK_OE && !DT_OE; endproperty
  a_off_quiet: assert property (p_off_quiet) else $error("pins driven while disabled");
  property p_slave_ck; slave [*2] |-> !CK_OE; endproperty
  a_slave_ck: assert property (p_slave_ck) else $error("clock pin driven as slave");
  property p_data_pin; rx_sync [*2] |-> !DT_OE; endproperty
  a_data_pin: assert property (p_data_pin) else $error("data pin driven in receive");
  property p_rsvd; RD && ADDR == `SSP_OFS_BCON |=> RDATA[5] == 1'b0 && RDATA[2] == 1'b0; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits nonzero");
  property p_thr_zero; RD && ADDR == `SSP_OFS_THR |=> RDATA == 8'h00; endproperty
  a_thr_zero: assert property (p_thr_zero) else $error("holding read nonzero");
  property p_hold; !$past(RD) |-> $stable(RDATA); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
endmodule
`default_nettype wire

// ===== test/ssp_master_model.sv
/*
  Behavioural external synchronous master: drives the shift clock and data.
  Assumes the bench resolves the data wire and feeds it back as dt_line.
*/
`default_nettype none
module ssp_master_model (
  output logic ck,
  output logic dt,
  input wire logic dt_line
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    ck = 1'b0;
    dt = 1'b1;
  end
  // =========================================
  // clock stands at its idle level between frames
  task automatic idle(input logic pol);
    ck = pol;
    #100;
  endtask
  // released data shows a changing pattern so stale bits cannot pass
  task automatic frame(input logic pol, input int n, input int half, input logic drive,
    input logic [8:0] tx, output logic [8:0] rx);
    rx = 9'h000;
    ck = pol;
    #(half);
    for (int i = 0; i < n; i++)
    begin
      ck = ~pol;
      dt = drive ? tx[i] : ~dt;
      #(half);
      ck = pol;
      rx[i] = dt_line;
      #(half);
    end
    dt = ~dt;
  endtask
endmodule
`default_nettype wire

// ===== test/tb_top.sv
/*
  Self-checking bench of ssp_core in synchronous slave use.
  Assumes the master model drives the link; reads are scored from a queue.
*/
`include "ssp_regs.svh"
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [7:0] e; logic [7:0] m;} ssp_exp_t;
  logic REF_CLK = 1'b0;
  logic RSTN = 1'b0;
  logic [2:0] ADDR = 3'h0;
  logic [7:0] WDATA = 8'h00;
  logic WR = 1'b0;
  logic RD = 1'b0;
  logic SLEEP = 1'b0;
  logic [7:0] RDATA;
  logic CK_OUT, CK_OE, DT_OUT, DT_OE, WAKE, IRQ;
  logic m_ck, m_dt, ck_line, dt_line;
  logic rd_seen = 1'b0;
  logic [31:0] seed = 32'h000006EA;
  logic [8:0] d, got;
  logic [8:0] w [3];
  int miscompares = 0;
  int tests_run = 0;
  int cyc = 0;
  ssp_exp_t exp_q[$];
  ssp_exp_t cur;
  always #2.5 REF_CLK = ~REF_CLK;
  assign ck_line = CK_OE ? CK_OUT : m_ck;
  assign dt_line = DT_OE ? DT_OUT : m_dt;
  ssp_core uut (.REF_CLK(REF_CLK), .RSTN(RSTN), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .SLEEP(SLEEP), .CK_IN(ck_line), .CK_OUT(CK_OUT), .CK_OE(CK_OE),
    .DT_IN(dt_line), .DT_OUT(DT_OUT), .DT_OE(DT_OE), .WAKE(WAKE), .IRQ(IRQ));
  ssp_master_model mst (.ck(m_ck), .dt(m_dt), .dt_line(dt_line));
  // =========================================
  // helpers
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic cmp(input string what, input logic [8:0] e, input logic [8:0] g);
    tests_run++;
    if (g !== e)
    begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge REF_CLK);
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    ADDR <= a;
    WDATA <= v;
    WR <= 1'b1;
    @(posedge REF_CLK);
    WR <= 1'b0;
    @(posedge REF_CLK);
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] e, input logic [7:0] m);
    exp_q.push_back('{e, m});
    ADDR <= a;
    RD <= 1'b1;
    @(posedge REF_CLK);
    RD <= 1'b0;
    @(posedge REF_CLK);
  endtask
  task automatic wait_wake;
    for (int i = 0; i < 60 && WAKE !== 1'b1; i++)
    begin
      @(posedge REF_CLK);
    end
  endtask
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // =========================================
  // read data is checked in the cycle after the strobe and holds until the next read
  always @(posedge REF_CLK)
  begin
    if (rd_seen)
    begin
      cur = exp_q.pop_front();
      cmp("rdata", {1'b0, cur.e & cur.m}, {1'b0, RDATA & cur.m});
    end
    rd_seen <= RD;
  end
  always @(posedge REF_CLK)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      miscompares++;
      test_done();
    end
  end
  // =========================================
  // main sequence
  initial
  begin
    repeat (10) @(posedge REF_CLK);
    RSTN <= 1'b1;
    @(posedge REF_CLK);
    rd(`SSP_OFS_TSC, 8'h02, 8'hFF);
    rd(`SSP_OFS_RSC, 8'h00, 8'hFF);
    rd(`SSP_OFS_BCON, 8'h40, 8'hFF);
    rd(`SSP_OFS_THR, 8'h00, 8'hFF);
    wr(`SSP_OFS_BCON, 8'h3C);
    rd(`SSP_OFS_BCON, 8'h58, 8'hFF);
    wr(`SSP_OFS_TSC, 8'hF5);
    rd(`SSP_OFS_TSC, 8'hF7, 8'hFF);
    wr(`SSP_OFS_RSC, 8'h7F);
    rd(`SSP_OFS_RSC, 8'h78, 8'hFF);
    $display("test registers done");
    for (int k = 0; k < 4; k++)
    begin
      d = 9'(xs());
      wr(`SSP_OFS_RSC, 8'h00);
      wr(`SSP_OFS_BCON, {3'b000, k[1], 4'h0});
      mst.idle(k[1]);
      idle(1);
      wr(`SSP_OFS_TSC, {1'b0, k[0], 2'b11, 3'b000, d[8]});
      wr(`SSP_OFS_RSC, 8'h80);
      wr(`SSP_OFS_INT, 8'h50);
      wr(`SSP_OFS_THR, d[7:0]);
      idle(3);
      rd(`SSP_OFS_TSC, {1'b0, k[0], 2'b11, 3'b000, d[8]}, 8'hFF);
      mst.frame(k[1], 8 + k[0], 40, 1'b0, 9'h000, got);
      cmp("tx word", k[0] ? d : {1'b0, d[7:0]}, k[0] ? got : {1'b0, got[7:0]});
      cmp("ck out", {8'h00, k[1]}, {8'h00, CK_OUT});
      idle(10);
      rd(`SSP_OFS_TSC, {1'b0, k[0], 2'b11, 3'b001, d[8]}, 8'hFF);
      rd(`SSP_OFS_INT, 8'h51, 8'hFF);
    end
    $display("test slave transmit done");
    wr(`SSP_OFS_RSC, 8'h00);
    wr(`SSP_OFS_BCON, 8'h00);
    mst.idle(1'b0);
    idle(1);
    wr(`SSP_OFS_TSC, 8'h30);
    wr(`SSP_OFS_RSC, 8'h80);
    w[0] = 9'(xs());
    w[1] = 9'(xs());
    wr(`SSP_OFS_THR, w[0][7:0]);
    wr(`SSP_OFS_THR, w[1][7:0]);
    idle(3);
    rd(`SSP_OFS_INT, 8'h50, 8'hFF);
    SLEEP <= 1'b1;
    for (int j = 0; j < 2; j++)
    begin
      mst.frame(1'b0, 8, 40, 1'b0, 9'h000, got);
      cmp("sleep tx", {1'b0, w[j][7:0]}, got);
      if (j == 0)
      begin
        wait_wake();
        cmp("tx wake", 9'h001, {8'h00, WAKE});
      end
    end
    idle(1);
    SLEEP <= 1'b0;
    $display("test sleep transmit done");
    wr(`SSP_OFS_RSC, 8'h00);
    wr(`SSP_OFS_INT, 8'hE0);
    wr(`SSP_OFS_RSC, 8'hD0);
    SLEEP <= 1'b1;
    for (int j = 0; j < 3; j++)
    begin
      w[j] = 9'(xs());
      mst.frame(1'b0, 9, 40, 1'b1, w[j], got);
      if (j == 0)
      begin
        wait_wake();
        cmp("rx wake", 9'h001, {8'h00, WAKE});
        cmp("rx irq", 9'h001, {8'h00, IRQ});
      end
    end
    idle(8);
    SLEEP <= 1'b0;
    for (int j = 0; j < 2; j++)
    begin
      rd(`SSP_OFS_RSC, {7'b1101001, w[j][8]}, 8'hFB);
      rd(`SSP_OFS_RDR, w[j][7:0], 8'hFF);
    end
    wr(`SSP_OFS_RSC, 8'hC0);
    rd(`SSP_OFS_RSC, 8'hC0, 8'hFA);
    idle(4);
    cmp("idle wake", 9'h000, {8'h00, WAKE});
    wr(`SSP_OFS_RSC, 8'h00);
    rd(`SSP_OFS_TSC, 8'h32, 8'hFF);
    idle(1);
    $display("test sleep receive done");
    test_done();
  end
endmodule
bind ssp_core ssp_checker u_chk (.REF_CLK(REF_CLK), .RSTN(RSTN), .ADDR(ADDR), .WDATA(WDATA),
  .WR(WR), .RD(RD), .RDATA(RDATA), .SLEEP(SLEEP), .CK_IN(CK_IN), .CK_OUT(CK_OUT),
  .CK_OE(CK_OE), .DT_IN(DT_IN), .DT_OUT(DT_OUT), .DT_OE(DT_OE), .WAKE(WAKE), .IRQ(IRQ));
`default_nettype wire
